// File: rtl/pcso_phase_cfg.sv
`timescale 1ns/1ns
`include "pcso_params.svh"

// Functional notes
// - Offset control bit 5 set enables the output offset; clear disables it.
// - Offset current magnitude comes from offset control bits 4 to 0.
// - Active offset sources current for negative offset, sinks it for positive.
// - Phase-count detection runs during the per-phase output pin configuration step.
// - A phase whose sense pin exceeds supply minus 0.5 V is disabled.
// - Phase count is latched at every configuration detection and then held.
// - Latched hardware count caps every requested phase count.
// - Pin n+1 pulled high selects n phases; no pin pulled gives 8.
// - Total current drives droop, total overcurrent and automatic phase dropping.
module pcso_phase_cfg
	import pcso_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic regWe,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic pinCfgActive,
	input wire logic [7:0] senseHigh,
	input wire logic [3:0] reqPhaseCount,
	input wire logic autoPhaseDrop,
	input wire logic [7:0] totalCurrentSignal,
	output logic [3:0] hwPhaseLimit,
	output logic [3:0] activePhaseCount,
	output logic [7:0] phaseEnable,
	output logic startFault,
	output logic detectDone,
	output pcso_offset_t offsetCmd,
	output logic [7:0] droopLevel,
	output logic totalOcp
);

	localparam logic [7:0] SETTLE_CYC = 8'(`PCSO_SETTLE_CYC);

	// Request of zero means "no limit"; anything above the cap is cut down
	function automatic logic [3:0] clampCount(input logic [3:0] req, input logic [3:0] lim);
		logic [3:0] r;
		r = (req == 4'h0) ? lim : req;
		return (r > lim) ? lim : r;
	endfunction : clampCount

	// Phase count needed to carry the present total current
	function automatic logic [3:0] apsNeed(input logic [7:0] cur);
		logic [3:0] n;
		n = {1'b0, cur[7:`PCSO_APS_STEP_SHIFT]} + 4'h1;
		return n;
	endfunction : apsNeed

	pcso_strap_t strapNow;

	pcso_strap_decode uDecode (
		.senseHigh(senseHigh),
		.strap(strapNow)
	);

	pcso_state_t state_r, state_nxt;
	logic [7:0] settleCnt_r, settleCnt_nxt;
	logic [7:0] senseSeen_r, senseSeen_nxt;
	logic [3:0] hwLimit_r, hwLimit_nxt;
	logic fault_r, fault_nxt;
	logic done_r, done_nxt;
	logic [3:0] active_r, active_nxt;
	logic [7:0] enable_r, enable_nxt;
	logic [7:0] droop_r, droop_nxt;
	logic ocp_r, ocp_nxt;
	logic [5:0] ofsReg_r, ofsReg_nxt;
	pcso_offset_t ofs_r, ofs_nxt;
	logic [7:0] rdData_r, rdData_nxt;
	logic latchNow;
	logic cfgPrev_r, cfgPrev_nxt;
	logic cfgRise;

	// Detection: wait for stable straps, latch at settle or at end of step
	always_comb begin
		state_nxt = state_r;
		settleCnt_nxt = settleCnt_r;
		senseSeen_nxt = senseHigh;
		hwLimit_nxt = hwLimit_r;
		fault_nxt = fault_r;
		done_nxt = done_r;
		latchNow = 1'b0;
		// Only a fresh step starts detection; a step held high would relatch forever
		cfgPrev_nxt = pinCfgActive;
		cfgRise = pinCfgActive && !cfgPrev_r;
		case (state_r)
			PCSO_IDLE, PCSO_LATCHED, PCSO_FAULT: begin
				if (cfgRise) begin
					state_nxt = PCSO_SETTLE;
					settleCnt_nxt = 8'h00;
					done_nxt = 1'b0;
				end
			end
			PCSO_SETTLE: begin
				// A bouncing pin restarts the settle window
				if (senseHigh != senseSeen_r) begin
					settleCnt_nxt = 8'h00;
				end else if (settleCnt_r != SETTLE_CYC) begin
					settleCnt_nxt = settleCnt_r + 8'h01;
				end
				latchNow = (settleCnt_r == SETTLE_CYC) || !pinCfgActive;
				if (latchNow) begin
					hwLimit_nxt = strapNow.count;
					fault_nxt = strapNow.fault;
					done_nxt = 1'b1;
					state_nxt = strapNow.fault ? PCSO_FAULT : PCSO_LATCHED;
				end
			end
			default: begin
				state_nxt = PCSO_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= PCSO_IDLE;
			settleCnt_r <= 8'h00;
			senseSeen_r <= 8'h00;
			hwLimit_r <= 4'h0;
			fault_r <= 1'b0;
			done_r <= 1'b0;
			cfgPrev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			settleCnt_r <= settleCnt_nxt;
			senseSeen_r <= senseSeen_nxt;
			hwLimit_r <= hwLimit_nxt;
			fault_r <= fault_nxt;
			done_r <= done_nxt;
			cfgPrev_r <= cfgPrev_nxt;
		end
	end

	// Phase drive: only once a legal count is latched, capped by the straps
	always_comb begin
		active_nxt = 4'h0;
		enable_nxt = 8'h00;
		droop_nxt = totalCurrentSignal;
		ocp_nxt = (totalCurrentSignal >= `PCSO_OCP_LEVEL);
		if (state_r == PCSO_LATCHED) begin
			active_nxt = clampCount(reqPhaseCount, hwLimit_r);
			if (autoPhaseDrop) begin
				active_nxt = clampCount(apsNeed(totalCurrentSignal), active_nxt);
			end
			for (int i = 0; i < `PCSO_MAX_PHASES; i++) begin
				enable_nxt[i] = (4'(i) < active_nxt);
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			active_r <= 4'h0;
			enable_r <= 8'h00;
			droop_r <= 8'h00;
			ocp_r <= 1'b0;
		end else begin
			active_r <= active_nxt;
			enable_r <= enable_nxt;
			droop_r <= droop_nxt;
			ocp_r <= ocp_nxt;
		end
	end

	// Offset control register; bits 7:6 are not stored and read as zero
	always_comb begin
		ofsReg_nxt = ofsReg_r;
		if (regWe && regAddr == `PCSO_OFFSET_CTRL_ADDR) begin
			ofsReg_nxt = regWrData[`PCSO_OFS_STORED_MSB:0];
		end
		rdData_nxt = `PCSO_UNMAPPED_READ;
		if (regAddr == `PCSO_OFFSET_CTRL_ADDR) begin
			rdData_nxt = {2'b00, ofsReg_r};
		end
		ofs_nxt.enable = ofsReg_r[`PCSO_OFS_EN_BIT];
		// Polarity bit is a guess; the magnitude still carries all five bits
		ofs_nxt.sourceCur = ofsReg_r[`PCSO_OFS_EN_BIT] && !ofsReg_r[`PCSO_OFS_POL_BIT];
		ofs_nxt.sinkCur = ofsReg_r[`PCSO_OFS_EN_BIT] && ofsReg_r[`PCSO_OFS_POL_BIT];
		ofs_nxt.magnitude = ofsReg_r[`PCSO_OFS_MAG_MSB:`PCSO_OFS_MAG_LSB];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ofsReg_r <= 6'(`PCSO_OFFSET_CTRL_RESET);
			ofs_r <= '0;
			rdData_r <= 8'h00;
		end else begin
			ofsReg_r <= ofsReg_nxt;
			ofs_r <= ofs_nxt;
			rdData_r <= rdData_nxt;
		end
	end

	// Outputs straight from flops
	assign regRdData = rdData_r;
	assign hwPhaseLimit = hwLimit_r;
	assign activePhaseCount = active_r;
	assign phaseEnable = enable_r;
	assign startFault = fault_r;
	assign detectDone = done_r;
	assign offsetCmd = ofs_r;
	assign droopLevel = droop_r;
	assign totalOcp = ocp_r;

	default clocking dc @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_OFS_ENABLE: assert property (
		regWe && regAddr == `PCSO_OFFSET_CTRL_ADDR |-> ##2 offsetCmd.enable == $past(regWrData[5], 2))
		else $error("offset enable does not follow written bit 5");

	AST_OFS_MAG: assert property (
		regWe && regAddr == `PCSO_OFFSET_CTRL_ADDR |-> ##2 offsetCmd.magnitude == $past(regWrData[4:0], 2))
		else $error("offset magnitude does not follow bits 4 to 0");

	AST_OFS_DIR: assert property (
		!(offsetCmd.sourceCur && offsetCmd.sinkCur) && ((offsetCmd.sourceCur || offsetCmd.sinkCur) == offsetCmd.enable))
		else $error("offset current direction inconsistent with enable");

	AST_DETECT_IN_STEP: assert property (
		$rose(detectDone) |-> $past(state_r) == PCSO_SETTLE)
		else $error("phase count latched outside configuration step");

	AST_SENSE_DISABLE: assert property (
		state_r == PCSO_SETTLE && latchNow && senseHigh[3] && !senseHigh[0] |=> hwPhaseLimit <= 4'h3)
		else $error("pulled sense pin did not disable its phase");

	AST_LATCH_HOLD: assert property (
		state_r == PCSO_LATCHED && !pinCfgActive |=> $stable(hwPhaseLimit))
		else $error("latched phase limit changed outside detection");

	AST_CAP: assert property (
		activePhaseCount <= hwPhaseLimit)
		else $error("active phase count exceeds hardware limit");

	AST_EIGHT_DEFAULT: assert property (
		state_r == PCSO_SETTLE && latchNow && senseHigh == 8'h00 |=> hwPhaseLimit == 4'h8)
		else $error("no pulled pin did not give eight phases");

	AST_OCP: assert property (
		totalCurrentSignal >= 8'he0 |=> totalOcp)
		else $error("total overcurrent not flagged");

	AST_DISABLED_OFF: assert property (
		state_r == PCSO_LATCHED && hwLimit_r == 4'h2 |=> phaseEnable[7:2] == 6'h00)
		else $error("disabled phase drive active");

	AST_FAULT_NO_SWITCH: assert property (
		startFault |-> phaseEnable == 8'h00 && activePhaseCount == 4'h0)
		else $error("switching not withheld on start-up fault");

endmodule : pcso_phase_cfg

// File: include/pcso_params.svh
`ifndef PCSO_PARAMS_SVH
`define PCSO_PARAMS_SVH

// Clock
`define PCSO_CLK_PERIOD_NS 8

// Register map, offsets, fields and reset value
`define PCSO_ADDR_W 8
`define PCSO_DATA_W 8
`define PCSO_OFFSET_CTRL_ADDR 8'h0e
`define PCSO_OFFSET_CTRL_RESET 8'h00
`define PCSO_OFS_EN_BIT 5
`define PCSO_OFS_POL_BIT 4
`define PCSO_OFS_MAG_MSB 4
`define PCSO_OFS_MAG_LSB 0
`define PCSO_OFS_STORED_MSB 5
`define PCSO_UNMAPPED_READ 8'h00

// Phase counts
`define PCSO_MAX_PHASES 8
`define PCSO_CNT_W 4
`define PCSO_MAX_COUNT 4'h8
`define PCSO_MIN_COUNT 4'h1

// Sense-pin settle time before the strap pattern is trusted
`define PCSO_SETTLE_NS 1000
`define PCSO_SETTLE_CYC ((`PCSO_SETTLE_NS + `PCSO_CLK_PERIOD_NS - 1) / `PCSO_CLK_PERIOD_NS)
`define PCSO_SETTLE_CNT_W 8

// Total-current thresholds, codes of the digitised sum current
`define PCSO_CUR_W 8
`define PCSO_OCP_LEVEL 8'he0
`define PCSO_APS_STEP_SHIFT 5

`endif

// File: include/pcso_pkg.sv
package pcso_pkg;

	// Detection sequencer, Gray along idle -> settle -> latched
	typedef enum logic [1:0] {
		PCSO_IDLE = 2'b00,
		PCSO_SETTLE = 2'b01,
		PCSO_LATCHED = 2'b11,
		PCSO_FAULT = 2'b10
	} pcso_state_t;

	// Result of decoding the strap pattern
	typedef struct packed {
		logic fault;
		logic [3:0] count;
	} pcso_strap_t;

	// Offset current command toward the analogue feedback stage
	typedef struct packed {
		logic enable;
		logic sourceCur;
		logic sinkCur;
		logic [4:0] magnitude;
	} pcso_offset_t;

endpackage : pcso_pkg

// File: rtl/pcso_strap_decode.sv
`timescale 1ns/1ns
`include "pcso_params.svh"

// Turns the per-phase "sense pin near supply" flags into a phase count
module pcso_strap_decode
	import pcso_pkg::*;
(
	input wire logic [7:0] senseHigh,
	output pcso_strap_t strap
);

	// Lowest pulled pin n+1 gives n phases; higher pins float and are ignored
	always_comb begin
		strap.fault = senseHigh[0];
		strap.count = `PCSO_MAX_COUNT;
		for (int i = `PCSO_MAX_PHASES - 1; i >= 1; i--) begin
			if (senseHigh[i]) begin
				strap.count = 4'(i);
			end
		end
		if (senseHigh[0]) begin
			strap.count = 4'h0;
		end
	end

endmodule : pcso_strap_decode

// File: test/pcso_strap_board.sv
`timescale 1ns/1ns

// Board wiring on the sense pins. Floating pins above the strap read high
// here, the worst case for a decoder that looks past the lowest strap.
module pcso_strap_board (
	input wire logic [3:0] cfgCount,
	input wire logic shortFirst,
	output logic [7:0] senseHigh
);
	// Pin n+1 tied to supply, higher pins floating, lower pins normal
	always_comb begin
		senseHigh = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (i >= cfgCount) begin
				senseHigh[i] = 1'b1;
			end
		end
		senseHigh[0] = shortFirst; // only a fault scenario sets it
	end
endmodule : pcso_strap_board

// File: test/tb_phase_count_strap_and_offset.sv
`timescale 1ns/1ns

module tb_phase_count_strap_and_offset;
	import pcso_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic regWe = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic pinCfgActive = 1'b0;
	logic [3:0] cfgCount = 4'h8;
	logic shortFirst = 1'b0;
	logic [3:0] reqPhaseCount = 4'h0;
	logic autoPhaseDrop = 1'b0;
	logic [7:0] ofsVals [5] = '{8'h25, 8'h35, 8'h1f, 8'hff, 8'h20};
	logic [7:0] totalCurrentSignal = 8'h00;
	logic [7:0] senseHigh, regRdData, phaseEnable, droopLevel, d;
	logic [3:0] hwPhaseLimit, activePhaseCount;
	logic startFault, detectDone, totalOcp;
	pcso_offset_t offsetCmd;
	int bad_count = 0;
	int samples_checked = 0;

	always #4 clk = ~clk;

	pcso_strap_board u_board (.cfgCount(cfgCount), .shortFirst(shortFirst), .senseHigh(senseHigh));

	pcso_phase_cfg u_dut (.clk(clk), .resetn(resetn), .regWe(regWe), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData), .pinCfgActive(pinCfgActive),
		.senseHigh(senseHigh), .reqPhaseCount(reqPhaseCount), .autoPhaseDrop(autoPhaseDrop),
		.totalCurrentSignal(totalCurrentSignal), .hwPhaseLimit(hwPhaseLimit),
		.activePhaseCount(activePhaseCount), .phaseEnable(phaseEnable),
		.startFault(startFault), .detectDone(detectDone), .offsetCmd(offsetCmd),
		.droopLevel(droopLevel), .totalOcp(totalOcp));

	task summarize;
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Inputs always move 1 ns after the rising edge
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task wr(input logic [7:0] a, input logic [7:0] v);
		regWe = 1'b1;
		regAddr = a;
		regWrData = v;
		tick(1);
		regWe = 1'b0;
	endtask : wr

	// Read data is registered, so give it two edges past the address
	task rd(input logic [7:0] a, input logic [7:0] e);
		regAddr = a;
		tick(2);
		chk(regRdData, e);
	endtask : rd

	// One configuration step, held for two edges after the strap pattern is latched
	task strap(input logic [3:0] c, input logic sf, input logic [3:0] req,
		input logic [3:0] lim, input logic [3:0] act, input logic [7:0] en);
		int n;
		cfgCount = c;
		shortFirst = sf;
		reqPhaseCount = req;
		pinCfgActive = 1'b1;
		tick(2);
		chk({7'h00, detectDone}, 8'h00);
		chk(phaseEnable, 8'h00);
		n = 0;
		while (detectDone !== 1'b1 && n < 400) begin
			tick(1);
			n++;
		end
		if (n >= 400) begin
			bad_count++;
			summarize();
		end
		chk({4'h0, hwPhaseLimit}, {4'h0, lim});
		chk({7'h00, startFault}, {7'h00, sf});
		// Step still running after the latch must not start a second detection
		tick(2);
		chk({7'h00, detectDone}, 8'h01);
		pinCfgActive = 1'b0;
		tick(1);
		chk({4'h0, activePhaseCount}, {4'h0, act});
		chk(phaseEnable, en);
	endtask : strap

	initial begin
		tick(4);
		resetn = 1'b1;
		tick(1);
		rd(8'h0e, 8'h00);
		// Enable, polarity and magnitude combinations, upper bits dropped
		foreach (ofsVals[i]) begin
			d = ofsVals[i];
			wr(8'h0e, d);
			tick(1);
			chk(offsetCmd, {d[5], d[5] & ~d[4], d[5] & d[4], d[4:0]});
			rd(8'h0e, {2'b00, d[5:0]});
		end
		wr(8'h0f, 8'haa);
		rd(8'h0f, 8'h00);
		rd(8'h0e, 8'h20);
		// Every strap setting, relatched step after step
		for (int k = 8; k >= 1; k--) begin
			strap(k[3:0], 1'b0, 4'h0, k[3:0], k[3:0], 8'hff >> (8 - k));
		end
		strap(4'h3, 1'b0, 4'h8, 4'h3, 4'h3, 8'h07);
		strap(4'h5, 1'b0, 4'h2, 4'h5, 4'h2, 8'h03);
		strap(4'h8, 1'b1, 4'h0, 4'h0, 4'h0, 8'h00);
		strap(4'h8, 1'b0, 4'h0, 4'h8, 4'h8, 8'hff);
		// Total current path at the overcurrent boundary
		totalCurrentSignal = 8'he0;
		tick(1);
		chk({7'h00, totalOcp}, 8'h01);
		chk(droopLevel, 8'he0);
		totalCurrentSignal = 8'hdf;
		tick(1);
		chk({7'h00, totalOcp}, 8'h00);
		// Automatic phase dropping by total current, under the latched eight
		autoPhaseDrop = 1'b1;
		totalCurrentSignal = 8'h20;
		tick(1);
		chk({4'h0, activePhaseCount}, 8'h02);
		chk(phaseEnable, 8'h03);
		totalCurrentSignal = 8'h00;
		tick(1);
		chk({4'h0, activePhaseCount}, 8'h01);
		chk(phaseEnable, 8'h01);
		autoPhaseDrop = 1'b0;
		summarize();
	end
endmodule : tb_phase_count_strap_and_offset
